// ### logic/fgc_consts.vh
// constants for the frame generator / checker statistics block
`ifndef FGC_CONSTS_VH
`define FGC_CONSTS_VH
`define FGC_IDX_CTRL        16'h40A0
`define FGC_IDX_LEN         16'h40A1
`define FGC_IDX_BURST       16'h40A2
`define FGC_IDX_RXG_H       16'h40A3
`define FGC_IDX_RXG_L       16'h40A4
`define FGC_IDX_RXO_H       16'h40A5
`define FGC_IDX_RXO_L       16'h40A6
`define FGC_IDX_RXU_H       16'h40A7
`define FGC_IDX_RXU_L       16'h40A8
`define FGC_IDX_RXCRC       16'h40A9
`define FGC_IDX_RXOE        16'h40AA
`define FGC_IDX_RXFRAG      16'h40AB
`define FGC_IDX_RXNOD       16'h40AC
`define FGC_IDX_TXG_H       16'h40AD
`define FGC_IDX_TXG_L       16'h40AE
`define FGC_IDX_TXO_H       16'h40AF
`define FGC_IDX_TXO_L       16'h40B0
`define FGC_IDX_TXU_H       16'h40B1
`define FGC_IDX_TXU_L       16'h40B2
`define FGC_IDX_IRQ_STAT    16'h40C8
`define FGC_IDX_IRQ_MASK    16'h40C9
`define FGC_CTRL_EN_BIT     12
`define FGC_LEN_RESET       16'h0040
`define FGC_BURST_RESET     16'h0000
`define FGC_MIN_LEN         16'h0040
`define FGC_MAX_LEN         16'h05EE
`define FGC_IRQ_DONE_BIT    0
`define FGC_IRQ_SAT_BIT     1
`endif

// ### logic/fgc_stats.v
// frame generator settings and frame checker statistics counters
// Notes on behaviour
// - generated frame length from length setting, reset 64
// - burst size sets frames per burst
// - 32-bit rx good count, clear-on-read halves
// - 32-bit rx oversize good-crc count
// - 32-bit rx undersize good-crc count
// - 16-bit rx crc error count, normal length
// - 16-bit rx crc error count, oversize
// - 16-bit rx fragment count, any crc
// - 16-bit rx missing delimiter count
// - 32-bit tx good count, clear-on-read halves
// - 32-bit tx oversize good-crc count
// - tx undersize count high half readable
// - burst zero runs forever; else self-clear enable
// - tx undersize low half separately readable
`timescale 1ns/10ps
`include "fgc_consts.vh"

module fgc_half_cnt #(
    parameter W = 16
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire         inc,
    input  wire         clr,
    output reg  [W-1:0] cnt_r,
    output wire         sat
);
    assign sat = &cnt_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {W{1'b0}};
        end else if (clr) begin
            cnt_r <= {{(W-1){1'b0}}, inc};
        end else if (inc && !sat) begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule // fgc_half_cnt

// a 32-bit counter as two halves each cleared by its own read; the
// carry into the high half only fires when the low half wraps, and
// the whole stops at all ones so no sample under-reports
module fgc_wide_cnt (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        inc,
    input  wire        clr_h,
    input  wire        clr_l,
    output wire [15:0] hi,
    output wire [15:0] lo,
    output wire        sat
);
    wire lo_full;
    wire hi_full;
    wire step;
    wire lo_inc;
    wire hi_inc;
    wire [15:0] lo_q;
    assign sat    = lo_full & hi_full;
    assign step   = inc & ~sat;
    assign hi_inc = step & lo_full;
    assign lo_inc = step;
    assign lo     = lo_q;
    reg  [15:0] lo_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_r <= 16'h0000;
        end else if (clr_l) begin
            lo_r <= {15'h0000, lo_inc & ~lo_full};
        end else if (lo_inc) begin
            lo_r <= lo_r + 16'h0001;
        end
    end
    assign lo_q    = lo_r;
    assign lo_full = &lo_r;
    fgc_half_cnt #(.W(16)) u_hi (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (hi_inc),
        .clr     (clr_h),
        .cnt_r   (hi),
        .sat     (hi_full)
    );
endmodule // fgc_wide_cnt

module fgc_stats (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        rx_frame_end,
    input  wire [15:0] rx_frame_len,
    input  wire        rx_crc_ok,
    input  wire        rx_delim_missing,
    input  wire        tx_frame_end,
    input  wire [15:0] tx_frame_len,
    input  wire        tx_crc_ok,
    input  wire        gen_frame_done,
    output wire        gen_active,
    output wire [15:0] gen_frame_length,
    output wire        irq
);
    reg  [15:0] len_r;
    reg  [15:0] burst_r;
    reg         gen_en_r;
    reg  [15:0] sent_r;
    reg  [1:0]  stat_r;
    reg  [1:0]  mask_r;
    wire [15:0] idx;
    wire        acc;
    wire        wr;
    wire        rd;
    wire        burst_end;
    wire        done_ev;
    wire        sat_ev;
    assign idx     = paddr[17:2];
    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    // clear-on-read acts at the setup edge, the edge that loads prdata,
    // so an event at that edge is counted from zero and never lost
    assign rd      = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    // unmapped words read zero and flag an error
    reg hit;
    assign pslverr = acc & ~hit;
    assign gen_frame_length = len_r;
    assign gen_active       = gen_en_r;
    assign burst_end = gen_en_r & gen_frame_done & (burst_r != 16'h0000) &
                       (sent_r + 16'h0001 == burst_r);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_r    <= `FGC_LEN_RESET;
            burst_r  <= `FGC_BURST_RESET;
            gen_en_r <= 1'b0;
            sent_r   <= 16'h0000;
        end else begin
            if (wr && idx == `FGC_IDX_LEN) begin
                len_r <= pwdata[15:0];
            end
            if (wr && idx == `FGC_IDX_BURST) begin
                burst_r <= pwdata[15:0];
            end
            if (wr && idx == `FGC_IDX_CTRL) begin
                gen_en_r <= pwdata[`FGC_CTRL_EN_BIT];
                sent_r   <= 16'h0000;
            end else if (burst_end) begin
                gen_en_r <= 1'b0;
                sent_r   <= 16'h0000;
            end else if (gen_en_r && gen_frame_done &&
                         burst_r != 16'h0000) begin
                sent_r <= sent_r + 16'h0001;
            end
        end
    end
    // classification of finished frames
    wire rx_short = rx_frame_len < `FGC_MIN_LEN;
    wire rx_long  = rx_frame_len > `FGC_MAX_LEN;
    wire tx_short = tx_frame_len < `FGC_MIN_LEN;
    wire tx_long  = tx_frame_len > `FGC_MAX_LEN;
    wire rx_ok    = rx_frame_end & ~rx_delim_missing;
    wire [9:0]  ev;
    assign ev[0]  = rx_ok & rx_crc_ok & ~rx_short & ~rx_long;
    assign ev[1]  = rx_ok & rx_crc_ok & rx_long;
    assign ev[2]  = rx_ok & rx_crc_ok & rx_short;
    assign ev[3]  = tx_frame_end & tx_crc_ok & ~tx_short & ~tx_long;
    assign ev[4]  = tx_frame_end & tx_crc_ok & tx_long;
    assign ev[5]  = tx_frame_end & tx_crc_ok & tx_short;
    assign ev[6]  = rx_ok & ~rx_crc_ok & ~rx_short & ~rx_long;
    assign ev[7]  = rx_ok & ~rx_crc_ok & rx_long;
    assign ev[8]  = rx_ok & rx_short;
    assign ev[9]  = rx_frame_end & rx_delim_missing;
    wire [15:0] whi [0:5];
    wire [15:0] wlo [0:5];
    wire [15:0] nar [0:3];
    wire [9:0]  sat;
    // one clear strobe per readable half; the narrow rx counters sit between
    // the rx and tx wide blocks in the index space, so no arithmetic on the index is used
    wire clr_rxg_h  = rd && idx == `FGC_IDX_RXG_H;
    wire clr_rxg_l  = rd && idx == `FGC_IDX_RXG_L;
    wire clr_rxo_h  = rd && idx == `FGC_IDX_RXO_H;
    wire clr_rxo_l  = rd && idx == `FGC_IDX_RXO_L;
    wire clr_rxu_h  = rd && idx == `FGC_IDX_RXU_H;
    wire clr_rxu_l  = rd && idx == `FGC_IDX_RXU_L;
    wire clr_rxcrc  = rd && idx == `FGC_IDX_RXCRC;
    wire clr_rxoe   = rd && idx == `FGC_IDX_RXOE;
    wire clr_rxfrag = rd && idx == `FGC_IDX_RXFRAG;
    wire clr_rxnod  = rd && idx == `FGC_IDX_RXNOD;
    wire clr_txg_h  = rd && idx == `FGC_IDX_TXG_H;
    wire clr_txg_l  = rd && idx == `FGC_IDX_TXG_L;
    wire clr_txo_h  = rd && idx == `FGC_IDX_TXO_H;
    wire clr_txo_l  = rd && idx == `FGC_IDX_TXO_L;
    wire clr_txu_h  = rd && idx == `FGC_IDX_TXU_H;
    wire clr_txu_l  = rd && idx == `FGC_IDX_TXU_L;

    fgc_wide_cnt u_rx_good (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[0]),
        .clr_h   (clr_rxg_h),
        .clr_l   (clr_rxg_l),
        .hi      (whi[0]),
        .lo      (wlo[0]),
        .sat     (sat[0])
    );

    fgc_wide_cnt u_rx_over (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[1]),
        .clr_h   (clr_rxo_h),
        .clr_l   (clr_rxo_l),
        .hi      (whi[1]),
        .lo      (wlo[1]),
        .sat     (sat[1])
    );

    fgc_wide_cnt u_rx_under (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[2]),
        .clr_h   (clr_rxu_h),
        .clr_l   (clr_rxu_l),
        .hi      (whi[2]),
        .lo      (wlo[2]),
        .sat     (sat[2])
    );

    fgc_wide_cnt u_tx_good (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[3]),
        .clr_h   (clr_txg_h),
        .clr_l   (clr_txg_l),
        .hi      (whi[3]),
        .lo      (wlo[3]),
        .sat     (sat[3])
    );

    fgc_wide_cnt u_tx_over (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[4]),
        .clr_h   (clr_txo_h),
        .clr_l   (clr_txo_l),
        .hi      (whi[4]),
        .lo      (wlo[4]),
        .sat     (sat[4])
    );

    fgc_wide_cnt u_tx_under (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[5]),
        .clr_h   (clr_txu_h),
        .clr_l   (clr_txu_l),
        .hi      (whi[5]),
        .lo      (wlo[5]),
        .sat     (sat[5])
    );

    fgc_half_cnt #(.W(16)) u_rx_crc (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[6]),
        .clr     (clr_rxcrc),
        .cnt_r   (nar[0]),
        .sat     (sat[6])
    );

    fgc_half_cnt #(.W(16)) u_rx_over_err (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[7]),
        .clr     (clr_rxoe),
        .cnt_r   (nar[1]),
        .sat     (sat[7])
    );

    fgc_half_cnt #(.W(16)) u_rx_frag (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[8]),
        .clr     (clr_rxfrag),
        .cnt_r   (nar[2]),
        .sat     (sat[8])
    );

    fgc_half_cnt #(.W(16)) u_rx_nodelim (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (ev[9]),
        .clr     (clr_rxnod),
        .cnt_r   (nar[3]),
        .sat     (sat[9])
    );

    // wide counters are not contiguous in index order; map by index
    reg [15:0] rval;
    always @* begin
        hit  = 1'b1;
        rval = 16'h0000;
        if (idx == `FGC_IDX_LEN) begin
            rval = len_r;
        end else if (idx == `FGC_IDX_CTRL) begin
            rval = {3'b000, gen_en_r, 12'h000};
        end else if (idx == `FGC_IDX_BURST) begin
            rval = burst_r;
        end else if (idx == `FGC_IDX_RXG_H) begin
            rval = whi[0];
        end else if (idx == `FGC_IDX_RXG_L) begin
            rval = wlo[0];
        end else if (idx == `FGC_IDX_RXO_H) begin
            rval = whi[1];
        end else if (idx == `FGC_IDX_RXO_L) begin
            rval = wlo[1];
        end else if (idx == `FGC_IDX_RXU_H) begin
            rval = whi[2];
        end else if (idx == `FGC_IDX_RXU_L) begin
            rval = wlo[2];
        end else if (idx == `FGC_IDX_RXCRC) begin
            rval = nar[0];
        end else if (idx == `FGC_IDX_RXOE) begin
            rval = nar[1];
        end else if (idx == `FGC_IDX_RXFRAG) begin
            rval = nar[2];
        end else if (idx == `FGC_IDX_RXNOD) begin
            rval = nar[3];
        end else if (idx == `FGC_IDX_TXG_H) begin
            rval = whi[3];
        end else if (idx == `FGC_IDX_TXG_L) begin
            rval = wlo[3];
        end else if (idx == `FGC_IDX_TXO_H) begin
            rval = whi[4];
        end else if (idx == `FGC_IDX_TXO_L) begin
            rval = wlo[4];
        end else if (idx == `FGC_IDX_TXU_H) begin
            rval = whi[5];
        end else if (idx == `FGC_IDX_TXU_L) begin
            rval = wlo[5];
        end else if (idx == `FGC_IDX_IRQ_STAT) begin
            rval = {14'h0000, stat_r};
        end else if (idx == `FGC_IDX_IRQ_MASK) begin
            rval = {14'h0000, mask_r};
        end else begin
            hit = 1'b0;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {16'h0000, rval};
        end
    end
    // sticky events; a new event beats a write-one clear
    assign done_ev = burst_end;
    assign sat_ev  = |sat;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= 2'b00;
            mask_r <= 2'b00;
        end else begin
            if (wr && idx == `FGC_IDX_IRQ_MASK) begin
                mask_r <= pwdata[1:0];
            end
            stat_r <= (stat_r & ~((wr && idx == `FGC_IDX_IRQ_STAT) ?
                       pwdata[1:0] : 2'b00)) | {sat_ev, done_ev};
        end
    end
    assign irq = |(stat_r & mask_r);
endmodule // fgc_stats

// ### test/fgc_stats_sva.sv
// checker: apb answer and generator port relations
`timescale 1ns/10ps
`include "fgc_consts.vh"
module fgc_stats_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gen_frame_done,
    input wire logic        gen_active,
    input wire logic [15:0] gen_frame_length
);
    wire        acc = psel && penable;
    wire        wa  = acc && pwrite;
    wire [15:0] ix  = paddr[17:2];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_len_reset: assert property ($rose(presetn)
        |-> gen_frame_length == `FGC_LEN_RESET) else $error("bad length");
    a_len_write: assert property (wa && ix == `FGC_IDX_LEN
        |=> gen_frame_length == $past(pwdata[15:0])) else $error("len wr");
    a_len_hold: assert property (!(wa && ix == `FGC_IDX_LEN)
        |=> $stable(gen_frame_length)) else $error("length moved");
    a_gen_start: assert property (wa && ix == `FGC_IDX_CTRL
        && pwdata[12] |=> gen_active) else $error("no start");
    a_gen_stop: assert property (wa && ix == `FGC_IDX_CTRL
        && !pwdata[12] |=> !gen_active) else $error("no stop");
    // self-clear only follows a finished frame, never on its own
    a_stop_cause: assert property ($fell(gen_active)
        |-> $past(gen_frame_done) || $past(wa)) else $error("bad stop");
    a_ready_now: assert property (psel |-> pready) else $error("wait");
    a_err_unmap: assert property (acc && ix == 16'h4000
        |-> pslverr && prdata == 32'h0) else $error("unmapped ok");
    a_err_mapped: assert property (acc && ix >= `FGC_IDX_CTRL
        && ix <= `FGC_IDX_TXU_L |-> !pslverr) else $error("mapped err");
    a_rd_steady: assert property (acc && !pwrite
        |=> $stable(prdata)) else $error("prdata moved");
    c_self_clear: cover property ($fell(gen_active));
    c_refused: cover property (acc && pslverr);
    c_sat_read: cover property (acc && ix == `FGC_IDX_RXFRAG
        && prdata[15:0] == 16'hFFFF);
endmodule // fgc_stats_sva
bind fgc_stats fgc_stats_sva fgc_stats_sva_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gen_frame_done(gen_frame_done),
    .gen_active(gen_active), .gen_frame_length(gen_frame_length));

// ### test/fgc_peer.sv
// far side model: frame checkers' end events and generator pacing
`timescale 1ns/10ps
module fgc_peer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        gen_active,
    output wire        rx_frame_end,
    output wire [15:0] rx_frame_len,
    output wire        rx_crc_ok,
    output wire        rx_delim_missing,
    output wire        tx_frame_end,
    output wire [15:0] tx_frame_len,
    output wire        tx_crc_ok,
    output reg         gen_frame_done
);
    reg        re = 0, rc = 0, rd = 0, te = 0, tc = 0;
    reg [15:0] rl = 0, tl = 0;
    reg [1:0]  pace;
    // qualifiers show the inverse outside an end pulse, never stale
    assign rx_frame_end = re;
    assign rx_frame_len = re ? rl : ~rl;
    assign rx_crc_ok = re ? rc : ~rc;
    assign rx_delim_missing = re ? rd : ~rd;
    assign tx_frame_end = te;
    assign tx_frame_len = te ? tl : ~tl;
    assign tx_crc_ok = te ? tc : ~tc;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace <= 2'h0;
            gen_frame_done <= 1'b0;
        end else begin
            pace <= pace + 2'h1;
            gen_frame_done <= gen_active && pace == 2'h3;
        end
    end
    task rx(input [15:0] l, input c, input d, input integer n);
        re <= 1; rl <= l; rc <= c; rd <= d;
        repeat (n) @(posedge pclk);
        re <= 0;
    endtask
    task tx(input [15:0] l, input c, input integer n);
        te <= 1; tl <= l; tc <= c;
        repeat (n) @(posedge pclk);
        te <= 0;
    endtask
endmodule // fgc_peer

// ### test/tb.sv
// testbench: apb tasks, counter model and scenarios
`timescale 1ns/10ps
`include "fgc_consts.vh"
module tb;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [31:0] paddr = 0, pwdata = 0, rdat;
    reg         rerr;
    wire [31:0] prdata;
    wire [15:0] rxl, txl, gen_frame_length;
    wire        pready, pslverr, rxe, rxc, rxd, txe, txc, gd, gen_active, irq;
    integer     seed = 43, miscompares = 0, check_count = 0, ndone = 0, i;
    int         m [16'h40A3:16'h40B2];
    int         bl [4] = '{63, 64, 1518, 1519};
    always #50 pclk = ~pclk;
    always @(posedge pclk) if (gd && gen_active) ndone = ndone + 1;
    fgc_stats fgc_stats_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_frame_end(rxe), .rx_frame_len(rxl), .rx_crc_ok(rxc),
        .rx_delim_missing(rxd), .tx_frame_end(txe), .tx_frame_len(txl),
        .tx_crc_ok(txc), .gen_frame_done(gd), .gen_active(gen_active),
        .gen_frame_length(gen_frame_length), .irq(irq));
    fgc_peer fgc_peer_inst (.pclk(pclk), .presetn(presetn),
        .gen_active(gen_active), .rx_frame_end(rxe), .rx_frame_len(rxl),
        .rx_crc_ok(rxc), .rx_delim_missing(rxd), .tx_frame_end(txe),
        .tx_frame_len(txl), .tx_crc_ok(txc), .gen_frame_done(gd));
    task close_out;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input [31:0] s, input [31:0] e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task ap(input w, input [15:0] a, input [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {14'h0, a, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata; rerr = pslverr; psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // model half is taken and zeroed first so a racing event lands after
    task rr(input [15:0] a);
        int e;
        e = m[a]; m[a] = 0; ap(0, a, 0);
        chk(rdat & 32'hFFFF, e);
    endtask
    task i16(input [15:0] a); if (m[a] != 16'hFFFF) m[a]++; endtask
    task i32(input [15:0] l, input [15:0] h);
        if (m[l] != 16'hFFFF) m[l]++;
        else if (m[h] != 16'hFFFF) begin m[l] = 0; m[h]++; end
    endtask
    task fr(input [15:0] l, input c, input d, input integer n);
        fgc_peer_inst.rx(l, c, d, n);
        repeat (n)
            if (d) i16(`FGC_IDX_RXNOD);
            else if (l < `FGC_MIN_LEN) begin
                i16(`FGC_IDX_RXFRAG);
                if (c) i32(`FGC_IDX_RXU_L, `FGC_IDX_RXU_H);
            end else if (l <= `FGC_MAX_LEN) begin
                if (c) i32(`FGC_IDX_RXG_L, `FGC_IDX_RXG_H);
                else i16(`FGC_IDX_RXCRC);
            end else if (c) i32(`FGC_IDX_RXO_L, `FGC_IDX_RXO_H);
            else i16(`FGC_IDX_RXOE);
        @(posedge pclk);
    endtask
    task ft(input [15:0] l, input c);
        fgc_peer_inst.tx(l, c, 1);
        if (c && l < `FGC_MIN_LEN) i32(`FGC_IDX_TXU_L, `FGC_IDX_TXU_H);
        else if (c && l <= `FGC_MAX_LEN) i32(`FGC_IDX_TXG_L, `FGC_IDX_TXG_H);
        else if (c) i32(`FGC_IDX_TXO_L, `FGC_IDX_TXO_H);
        @(posedge pclk);
    endtask
    task rall; for (i = `FGC_IDX_RXG_H; i <= `FGC_IDX_TXU_L; i++) rr(i); endtask
    initial begin
        #9000000;
        miscompares++;
        close_out;
    end
    initial begin
        foreach (m[k]) m[k] = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        ap(0, `FGC_IDX_LEN, 0); chk(rdat, 32'h0040);
        ap(0, `FGC_IDX_BURST, 0); chk(rdat, 32'h0);
        rall;
        ap(0, 16'h4000, 0); chk(rerr, 1); chk(rdat, 0);
        ap(1, `FGC_IDX_RXCRC, 32'h0005); rr(`FGC_IDX_RXCRC);
        ap(1, `FGC_IDX_LEN, 32'hABCD); chk(gen_frame_length, 16'hABCD);
        $display("test registers done");
        ap(1, `FGC_IDX_BURST, 32'h0003); ndone = 0;
        ap(1, `FGC_IDX_CTRL, 32'h1000);
        for (i = 0; i < 100 && gen_active === 1'b1; i++) @(posedge pclk);
        chk(gen_active, 0);
        chk(ndone, 3);
        chk(irq, 0); ap(1, `FGC_IDX_IRQ_MASK, 32'h1); chk(irq, 1);
        ap(1, `FGC_IDX_IRQ_STAT, 32'h1); chk(irq, 0);
        ap(1, `FGC_IDX_BURST, 32'h0); ap(1, `FGC_IDX_CTRL, 32'h1000);
        repeat (40) @(posedge pclk);
        chk(gen_active, 1);
        ap(1, `FGC_IDX_CTRL, 32'h0); chk(gen_active, 0);
        $display("test generator done");
        for (i = 0; i < 48; i++) begin
            fr(i < 8 ? bl[i%4] : $unsigned($random(seed)) % 1600,
               i < 8 ? i[2] : $random(seed), ($random(seed) & 3) == 0, 1);
            ft(i < 8 ? bl[i%4] : $unsigned($random(seed)) % 1600,
               i < 8 ? i[2] : $random(seed));
        end
        rall;
        $display("test classes done");
        fr(16'h0064, 1, 0, 1);
        fork
            rr(`FGC_IDX_RXG_L);
            begin @(posedge pclk); fr(16'h0064, 1, 0, 1); end
        join
        rr(`FGC_IDX_RXG_L);
        fork
            rr(`FGC_IDX_RXG_L);
            fr(16'h0064, 1, 0, 1);
        join
        rr(`FGC_IDX_RXG_L);
        $display("test read race done");
        fr(16'h000A, 1, 0, 65537);
        ap(0, `FGC_IDX_IRQ_STAT, 0); chk(rdat[1], 1);
        rr(`FGC_IDX_RXFRAG); rr(`FGC_IDX_RXU_H); rr(`FGC_IDX_RXU_L);
        ap(1, `FGC_IDX_IRQ_STAT, 32'h2);
        fr(16'h000A, 1, 0, 1); rr(`FGC_IDX_RXFRAG);
        $display("test saturation done");
        close_out;
    end
endmodule // tb
